//--- hw/sarseq_pkg.sv
package sarseq_pkg;

    // ========================================================================
    // sizes and timing
    // ========================================================================
    localparam int          RESULT_BITS     = 10;
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          VALID_DELAY_NS  = 500;
    // longest time rounds down, never below one cycle
    localparam int          VALID_CYCLES_RAW = VALID_DELAY_NS / CLK_PERIOD_NS;
    localparam int          VALID_CYCLES    =
        (VALID_CYCLES_RAW < 1) ? 1 : VALID_CYCLES_RAW;
    // delay used between flag fall and data drive, well inside the limit
    localparam logic [3:0]  DRIVE_DELAY     = 4'h1;
    localparam logic [9:0]  RESULT_RESET    = 10'h000;
    localparam logic [9:0]  MSB_MASK        = 10'h200;

    typedef enum logic [1:0] {
        SARSEQ_IDLE,
        SARSEQ_TRIAL,
        SARSEQ_DONE
    } sarseq_state_t;

    // result group as presented at the pins
    typedef struct packed {
        logic [9:0] data;
        logic [9:0] data_oe;
    } sarseq_out_t;

endpackage

//--- hw/sarseq_top.sv
`timescale 1ns/10ps

module sarseq_top
    import sarseq_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_blank_convert,
    input  wire logic                   i_comp_sum_low,
    output logic      [RESULT_BITS-1:0] o_dac_code,
    output logic      [RESULT_BITS-1:0] o_data,
    output logic      [RESULT_BITS-1:0] o_data_oe,
    output logic                        o_conversion_done_n,
    output logic                        o_conversion_done_oe
);

    // ========================================================================
    // input synchroniser
    // ========================================================================
    logic               bc_meta;
    logic               bc_sync;
    logic               bc_prev;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            bc_meta <= 1'b1;
            bc_sync <= 1'b1;
            bc_prev <= 1'b1;
        end
        else
        begin
            bc_meta <= i_blank_convert;
            bc_sync <= bc_meta;
            bc_prev <= bc_sync;
        end
    end

    wire start_conv = bc_prev & ~bc_sync;

    // ========================================================================
    // sequencer
    // ========================================================================
    sarseq_state_t                 state;
    logic [RESULT_BITS-1:0]        approx_result_register;
    logic [RESULT_BITS-1:0]        trial_bit;
    logic [3:0]                    drive_cnt;
    sarseq_out_t                   pins;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state                  <= SARSEQ_IDLE;
            approx_result_register <= RESULT_RESET;
            trial_bit              <= RESULT_RESET;
        end
        else
        begin
            case (state)
                SARSEQ_IDLE:
                begin
                    if (start_conv)
                    begin
                        // MSB tried first
                        approx_result_register <= MSB_MASK;
                        trial_bit              <= MSB_MASK;
                        state                  <= SARSEQ_TRIAL;
                    end
                end
                SARSEQ_TRIAL:
                begin
                    if (bc_sync)
                    begin
                        // halt; register rearmed, flag and data pins untouched, dac code returns to zero
                        approx_result_register <= RESULT_RESET;
                        trial_bit              <= RESULT_RESET;
                        state                  <= SARSEQ_IDLE;
                    end
                    else
                    begin
                        // decide current bit, raise next one
                        approx_result_register <=
                            (i_comp_sum_low ? approx_result_register
                                            : (approx_result_register
                                               & ~trial_bit))
                            | (trial_bit >> 1);
                        trial_bit <= trial_bit >> 1;
                        if (trial_bit[0])
                            state <= SARSEQ_DONE;
                    end
                end
                SARSEQ_DONE:
                begin
                    if (bc_sync)
                    begin
                        approx_result_register <= RESULT_RESET;
                        state                  <= SARSEQ_IDLE;
                    end
                end
                default:
                    state <= SARSEQ_IDLE;
            endcase
        end
    end

    // ========================================================================
    // completion flag and result buffers
    // ========================================================================
    // pins are only touched at finish, when the drive delay runs out, and at blank; a halted conversion
    // leaves whatever the last result showed
    wire finish = (state == SARSEQ_TRIAL) && !bc_sync && trial_bit[0];

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_conversion_done_n <= 1'b1;
            drive_cnt           <= 4'h0;
            pins                <= '0;
        end
        else
        begin
            if (finish)
            begin
                o_conversion_done_n <= 1'b0;
                drive_cnt           <= DRIVE_DELAY;
                pins.data <= i_comp_sum_low
                    ? approx_result_register
                    : (approx_result_register & ~trial_bit);
            end
            else if (state == SARSEQ_DONE && bc_sync)
            begin
                o_conversion_done_n <= 1'b1;
                pins.data_oe        <= '0;
                drive_cnt           <= 4'h0;
            end
            else if (drive_cnt != 4'h0)
            begin
                drive_cnt <= drive_cnt - 4'h1;
                if (drive_cnt == 4'h1)
                    pins.data_oe <= '1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_dac_code           <= '0;
            o_data               <= '0;
            o_data_oe            <= '0;
            o_conversion_done_oe <= 1'b0;
        end
        else
        begin
            o_dac_code           <= approx_result_register;
            o_data               <= pins.data;
            o_data_oe            <= pins.data_oe;
            // open-collector style: enable is the flag inverted one cycle late, so it drives high for a cycle at release
            o_conversion_done_oe <= ~o_conversion_done_n;
        end
    end

    // ========================================================================
    // checks
    // ========================================================================
    property p_order;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_IDLE && start_conv) |=>
            (trial_bit == MSB_MASK);
    endproperty
    a_order: assert property (p_order) else $error("msb not first");

    property p_keep;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_TRIAL && !bc_sync && !trial_bit[0]
         && i_comp_sum_low) |=>
            ((approx_result_register & $past(trial_bit)) != '0);
    endproperty
    a_keep: assert property (p_keep) else $error("bit not kept");

    property p_clear;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_TRIAL && !bc_sync && !trial_bit[0]
         && !i_comp_sum_low) |=>
            ((approx_result_register & $past(trial_bit)) == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("bit not cleared");

    // trial length is counted here; a ten-fold repetition unrolls badly
    logic [3:0]                    trial_len;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            trial_len <= 4'h0;
        else if (state == SARSEQ_TRIAL)
            trial_len <= trial_len + 4'h1;
        else
            trial_len <= 4'h0;
    end

    property p_len;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        finish |-> (trial_len == 4'(RESULT_BITS - 1));
    endproperty
    a_len: assert property (p_len) else $error("not ten trials");

    property p_flag;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        finish |=> !o_conversion_done_n;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not low");

    property p_drive;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $fell(o_conversion_done_n) |-> ##[1:5] (o_data_oe == '1);
    endproperty
    a_drive: assert property (p_drive) else $error("data late");

    property p_oe_flag;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (o_data_oe != '0) |-> !$past(o_conversion_done_n);
    endproperty
    a_oe_flag: assert property (p_oe_flag)
        else $error("outputs driven without flag");

    property p_blank;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_DONE && bc_sync) |=> ##1 (o_data_oe == '0);
    endproperty
    a_blank: assert property (p_blank) else $error("not blanked");

    property p_halt;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_TRIAL && bc_sync) |=>
            ($stable(o_conversion_done_n) && state == SARSEQ_IDLE
             && $stable(o_data) && $stable(o_data_oe));
    endproperty
    a_halt: assert property (p_halt) else $error("halt changed flag");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state == SARSEQ_TRIAL && !finish) |=> $stable(o_conversion_done_n);
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved early");

endmodule

//--- tb/sarseq_cmp_model.sv
`timescale 1ns/10ps

// ============================================================================
// comparator at the far side of the trial register
// ============================================================================
module sarseq_cmp_model
    import sarseq_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_blank_convert,
    input  wire logic [RESULT_BITS-1:0] i_target,
    output logic                        o_comp_sum_low
);
    int cnt;

    always @(posedge i_sys_clk)
        cnt <= i_blank_convert ? 0 : cnt + 1;

    // decision for the bit on trial follows the handed-over walk, msb first;
    // outside trials it toggles while blank is low so a stray sample never looks like a result
    always_comb
        o_comp_sum_low = (cnt >= 3 && cnt <= 12) ? i_target[12-cnt]
                                                 : cnt[0];
endmodule

//--- tb/sarseq_top_tb.sv
`timescale 1ns/10ps

module sarseq_top_tb;
    import sarseq_pkg::*;

    typedef struct packed {
        logic [RESULT_BITS-1:0] target;
        logic [RESULT_BITS-1:0] result;
    } sarseq_row_t;

    logic                   clk;
    logic                   rst_n;
    logic                   blank;
    logic                   comp;
    logic [RESULT_BITS-1:0] target;
    logic [RESULT_BITS-1:0] data;
    logic [RESULT_BITS-1:0] data_oe;
    logic [RESULT_BITS-1:0] dac;
    logic                   done_n;
    logic                   done_oe;
    int                     error_cnt;
    int                     samples_checked;
    int                     cycles;
    int                     lat;
    sarseq_row_t            rows [6] = '{'{10'h000, 10'h000},
        '{10'h3ff, 10'h3ff}, '{10'h200, 10'h200}, '{10'h1ff, 10'h1ff},
        '{10'h155, 10'h155}, '{10'h001, 10'h001}};

    sarseq_top dut (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_blank_convert(blank), .i_comp_sum_low(comp), .o_dac_code(dac),
        .o_data(data), .o_data_oe(data_oe), .o_conversion_done_n(done_n),
        .o_conversion_done_oe(done_oe));

    sarseq_cmp_model cmp (.i_sys_clk(clk), .i_blank_convert(blank),
        .i_target(target), .o_comp_sum_low(comp));

    // ========================================================================
    // helpers
    // ========================================================================
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [RESULT_BITS-1:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // blank held 2 us so every start is a full restart
    task automatic convert(input logic [RESULT_BITS-1:0] t);
        target = t;
        blank  = 1'b1;
        tick(20);
        blank  = 1'b0;
        lat    = 0;
        while (done_n !== 1'b0 && lat < 40)
        begin
            tick(1);
            lat++;
        end
    endtask

    task automatic end_sim;
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    // ========================================================================
    // sequence
    // ========================================================================
    initial
    begin
        rst_n = 1'b0;
        blank = 1'b1;
        target = 10'h000;
        tick(4);
        chk({9'h000, done_n}, 10'h001);
        chk(data_oe, 10'h000);
        rst_n = 1'b1;
        tick(2);
        foreach (rows[i])
        begin
            convert(rows[i].target);
            chk(10'(lat), 10'h00d);
            tick(4);
            chk(data, rows[i].result);
            chk(data_oe, 10'h3ff);
            chk({9'h000, done_oe}, 10'h001);
        end
        // blanking a held result floats the pins and rearms the register
        blank = 1'b1;
        tick(16);
        chk({9'h000, done_n}, 10'h001);
        chk(data_oe, 10'h000);
        chk({9'h000, done_oe}, 10'h000);
        chk(dac, 10'h000);
        // halt in mid-conversion: pins keep the old result, then restart
        target = 10'h0f0;
        blank  = 1'b0;
        tick(6);
        blank  = 1'b1;
        tick(12);
        chk({9'h000, done_n}, 10'h001);
        chk(data_oe, 10'h000);
        chk(data, 10'h001);
        chk(dac, 10'h000);
        convert(10'h2aa);
        chk(10'(lat), 10'h00d);
        tick(4);
        chk(data, 10'h2aa);
        // reset while a result is held clears the flag and floats the pins
        rst_n = 1'b0;
        tick(1);
        chk({9'h000, done_n}, 10'h001);
        chk(data_oe, 10'h000);
        chk(dac, 10'h000);
        // release with blank high so no false start follows
        blank = 1'b1;
        tick(2);
        rst_n = 1'b1;
        tick(2);
        chk({9'h000, done_n}, 10'h001);
        convert(10'h0f0);
        chk(10'(lat), 10'h00d);
        tick(4);
        chk(data, 10'h0f0);
        end_sim();
    end
endmodule
